// *** hdl/odsc_pkg.sv ***
// Constants, register map and carrier types for the output divider and sync control.
// Assumes one 20 MHz system clock; prescaler ticks arrive as same-clock enables.
package odsc_pkg;
    localparam int NUM_OUT = 8;
    localparam int ADDR_W = 5;
    localparam int INT_W = 10;
    localparam int FRAC_W = 20;
    localparam int PRE_W = 8;
    localparam int PS_W = 3;

    // Register offsets
    localparam logic [ADDR_W-1:0] REG_PRESCALE = 5'h00;
    localparam logic [ADDR_W-1:0] REG_LOOP = 5'h01;
    localparam logic [ADDR_W-1:0] REG_OUT_EN = 5'h02;
    localparam logic [ADDR_W-1:0] REG_SYNC = 5'h03;
    localparam logic [ADDR_W-1:0] REG_STATUS = 5'h04;
    localparam logic [ADDR_W-1:0] REG_FMT = 5'h05;
    localparam logic [ADDR_W-1:0] REG_INT_BASE = 5'h08;
    localparam logic [ADDR_W-1:0] REG_FRAC_BASE = 5'h10;

    // Field positions
    localparam int SOFT_SYNC_POS = 5;
    localparam int PS_A_LSB = 0;
    localparam int PS_B_LSB = 8;
    localparam int R3_LSB = 0;
    localparam int C3_LSB = 4;
    localparam int FRAC_EN_LSB = 31;
    localparam int FRAC_PRE_LSB = 20;
    localparam int BYP_SEL_LSB = 28;

    // Reset values and fractional pre-divide minimum
    localparam logic [31:0] RST_PRESCALE = 32'h0000_0404;
    localparam logic [31:0] RST_LOOP = 32'h0000_0000;
    localparam logic [NUM_OUT-1:0] RST_OUT_EN = 8'h00;
    localparam logic [INT_W-1:0] RST_INT_DIV = 10'h001;
    localparam logic [31:0] RST_FRAC = 32'h0020_0000;
    localparam logic [PRE_W-1:0] MIN_FRAC_PRE = 8'h02;

    // Timing of release: first edge target 15 to 20 ns
    localparam int SYNC_DLY_MIN_NS = 15;
    localparam int SYNC_DLY_MAX_NS = 20;
    localparam int CLK_NS = 50;
    localparam int SYNC_DLY_CYC = (SYNC_DLY_MAX_NS / CLK_NS) < 1 ? 1 : SYNC_DLY_MAX_NS / CLK_NS;

    typedef enum logic [1:0] {ODSC_FMT_LVDS, ODSC_FMT_HIGH, ODSC_FMT_MID} odsc_fmt_t;
    typedef enum logic [1:0] {ODSC_BYP_FRAC, ODSC_BYP_PRI, ODSC_BYP_SEC} odsc_byp_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } odsc_bus_req_t;

    typedef struct packed {
        logic [1:0] fmt;
        logic slow_slew;
        logic dual_cmos;
    } odsc_drv_t;
endpackage

// *** hdl/odsc_divider.sv ***
// One output divider: integer counter or fractional pre-divider plus sigma-delta.
// Assumes tick is a one-cycle prescaler enable on the same clock.
`timescale 1ns/1ps
module odsc_divider
    import odsc_pkg::*;
#(
    parameter int IW = INT_W,
    parameter int FW = FRAC_W,
    parameter int PW = PRE_W
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Control
    input wire logic hold,
    input wire logic tick,
    input wire logic frac_en,
    input wire logic [IW-1:0] int_div,
    input wire logic [PW-1:0] pre_div,
    input wire logic [FW-1:0] frac_word,
    // Result
    output logic clk_out
);
    logic [IW-1:0] cnt_ff;
    logic [PW:0] pcnt_ff;
    logic [FW:0] acc_ff;
    logic extra_ff;
    logic out_ff;
    logic [IW-1:0] int_half;
    logic [PW:0] pre_len;
    logic [FW:0] acc_sum;

    assign int_half = int_div >> 1;
    assign acc_sum = {1'b0, acc_ff[FW-1:0]} + {1'b0, frac_word};
    // Period is pre_div or pre_div+1 by accumulator carry
    assign pre_len = {1'b0, pre_div} + {{PW{1'b0}}, extra_ff};

    // Integer path: single continuous counter
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= '0;
        end else if (hold) begin
            cnt_ff <= '0;
        end else if (tick && !frac_en) begin
            cnt_ff <= (cnt_ff + 1'b1 >= int_div) ? '0 : cnt_ff + 1'b1;
        end
    end

    // Fractional path: pre-divider with first-order sigma-delta
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pcnt_ff <= '0;
            acc_ff <= '0;
            extra_ff <= 1'b0;
        end else if (hold) begin
            pcnt_ff <= '0;
            acc_ff <= '0;
            extra_ff <= 1'b0;
        end else if (tick && frac_en) begin
            if (pcnt_ff + 1'b1 >= pre_len) begin
                pcnt_ff <= '0;
                acc_ff <= acc_sum;
                extra_ff <= acc_sum[FW];
            end else begin
                pcnt_ff <= pcnt_ff + 1'b1;
            end
        end
    end

    // Cleared fractional enable selects the integer counter
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            out_ff <= 1'b0;
        end else if (hold) begin
            out_ff <= 1'b0;
        end else if (frac_en) begin
            out_ff <= (pcnt_ff < (pre_len >> 1));
        end else begin
            out_ff <= (int_div <= 1) ? tick : (cnt_ff < int_half);
        end
    end

    assign clk_out = out_ff;
endmodule

// *** hdl/odsc_top.sv ***
// Output divider, bypass mux, format and synchronization control for eight outputs.
// Assumes synchronous register port; sync pin and input clocks are asynchronous.
//
// Chosen here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module odsc_top
    import odsc_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Pins
    input wire logic output_sync_request_n,
    input wire logic pri_clk_in,
    input wire logic sec_clk_in,
    // Clock outputs, output enable active low
    output logic [NUM_OUT-1:0] clk_out,
    output logic [NUM_OUT-1:0] clk_out_oe_b,
    output logic [NUM_OUT-1:0] clk_out_aux,
    output logic [NUM_OUT-1:0] clk_out_aux_oe_b,
    // Analog control
    output logic [3:0] third_pole_resistor,
    output logic [3:0] third_pole_capacitor,
    output odsc_drv_t [NUM_OUT-1:0] drv_cfg
);
    logic rst_meta_ff, rst_sync_ff;
    logic sync_meta_ff, sync_pin_ff;
    logic pri_meta_ff, pri_ff, sec_meta_ff, sec_ff;
    logic [31:0] prescale_ff, loop_ff, fmt_ff, sync_reg_ff;
    logic [NUM_OUT-1:0] out_en_ff;
    logic [INT_W-1:0] int_div_ff [NUM_OUT];
    logic [31:0] frac_ff [4];
    logic [PS_W-1:0] ps_a_cnt_ff, ps_b_cnt_ff;
    logic tick_a_ff, tick_b_ff;
    logic sync_req, soft_sync;
    logic rel_latch_ff;
    logic [1:0] rel_a_ff, rel_b_ff;
    logic run_a_ff, run_b_ff;
    logic [NUM_OUT-1:0] div_out, run_sel;
    logic [NUM_OUT-1:0] out_ff, oe_b_ff, aux_ff, aux_oe_b_ff;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [PS_W-1:0] ps_a_div, ps_b_div;

    // Reset release through two flops
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    // Pin synchronisers; sync pin resets to its idle high level, clock pins reset low
    always_ff @(posedge clock or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            sync_meta_ff <= 1'b1;
            sync_pin_ff <= 1'b1;
            pri_meta_ff <= 1'b0;
            pri_ff <= 1'b0;
            sec_meta_ff <= 1'b0;
            sec_ff <= 1'b0;
        end else begin
            sync_meta_ff <= output_sync_request_n;
            sync_pin_ff <= sync_meta_ff;
            pri_meta_ff <= pri_clk_in;
            pri_ff <= pri_meta_ff;
            sec_meta_ff <= sec_clk_in;
            sec_ff <= sec_meta_ff;
        end
    end

    // Register writes
    always_ff @(posedge clock or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            prescale_ff <= RST_PRESCALE;
            loop_ff <= RST_LOOP;
            fmt_ff <= '0;
            sync_reg_ff <= '0;
            out_en_ff <= RST_OUT_EN;
        end else if (reg_wr) begin
            unique case (reg_addr)
                REG_PRESCALE: prescale_ff <= reg_wdata;
                REG_LOOP: loop_ff <= reg_wdata;
                REG_OUT_EN: out_en_ff <= reg_wdata[NUM_OUT-1:0];
                REG_SYNC: sync_reg_ff <= reg_wdata;
                REG_FMT: fmt_ff <= reg_wdata;
                default: ;
            endcase
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_OUT; gi++) begin : g_int
            always_ff @(posedge clock or negedge rst_sync_ff) begin
                if (!rst_sync_ff) begin
                    int_div_ff[gi] <= RST_INT_DIV;
                end else if (reg_wr && reg_addr == REG_INT_BASE + ADDR_W'(gi)) begin
                    int_div_ff[gi] <= reg_wdata[INT_W-1:0];
                end
            end
        end
        for (gi = 0; gi < 4; gi++) begin : g_frac
            // Pre-divide below two is clamped; software must avoid it
            always_ff @(posedge clock or negedge rst_sync_ff) begin
                if (!rst_sync_ff) begin
                    frac_ff[gi] <= RST_FRAC;
                end else if (reg_wr && reg_addr == REG_FRAC_BASE + ADDR_W'(gi)) begin
                    frac_ff[gi] <= reg_wdata;
                    if (reg_wdata[FRAC_PRE_LSB +: PRE_W] < MIN_FRAC_PRE) begin
                        frac_ff[gi][FRAC_PRE_LSB +: PRE_W] <= MIN_FRAC_PRE;
                    end
                end
            end
        end
    endgenerate

    assign ps_a_div = prescale_ff[PS_A_LSB +: PS_W];
    assign ps_b_div = prescale_ff[PS_B_LSB +: PS_W];

    // Prescaler ticks; both restart only from reset, so settings align if kept equal since reset
    always_ff @(posedge clock or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            ps_a_cnt_ff <= '0;
            ps_b_cnt_ff <= '0;
            tick_a_ff <= 1'b0;
            tick_b_ff <= 1'b0;
        end else begin
            ps_a_cnt_ff <= (ps_a_cnt_ff + 1'b1 >= ps_a_div) ? '0 : ps_a_cnt_ff + 1'b1;
            ps_b_cnt_ff <= (ps_b_cnt_ff + 1'b1 >= ps_b_div) ? '0 : ps_b_cnt_ff + 1'b1;
            tick_a_ff <= (ps_a_cnt_ff == '0);
            tick_b_ff <= (ps_b_cnt_ff == '0);
        end
    end

    // Either source requests sync
    assign soft_sync = sync_reg_ff[SOFT_SYNC_POS];
    assign sync_req = !sync_pin_ff || soft_sync;

    // Release: latch, then retime on prescaler ticks
    always_ff @(posedge clock or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            rel_latch_ff <= 1'b0;
            rel_a_ff <= '0;
            rel_b_ff <= '0;
            run_a_ff <= 1'b0;
            run_b_ff <= 1'b0;
        end else if (sync_req) begin
            rel_latch_ff <= 1'b0;
            rel_a_ff <= '0;
            rel_b_ff <= '0;
            run_a_ff <= 1'b0;
            run_b_ff <= 1'b0;
        end else begin
            rel_latch_ff <= 1'b1;
            if (tick_a_ff) begin
                rel_a_ff <= {rel_a_ff[0], rel_latch_ff};
            end
            if (tick_b_ff) begin
                rel_b_ff <= {rel_b_ff[0], rel_latch_ff};
            end
            // Group A and group B start on their own prescaler
            run_a_ff <= rel_a_ff[1];
            run_b_ff <= rel_b_ff[1];
        end
    end

    // Group membership: A holds 0,1,4,5
    localparam logic [NUM_OUT-1:0] GROUP_A = 8'h33;

    generate
        for (gi = 0; gi < NUM_OUT; gi++) begin : g_div
            localparam bit IS_A = GROUP_A[gi];
            localparam bit IS_F = (gi >= 4);
            assign run_sel[gi] = IS_A ? run_a_ff : run_b_ff;
            // Lower outputs have no fractional word, so never index below zero
            if (IS_F) begin : g_f
                odsc_divider u_div (
                    .clock(clock),
                    .rst_n(rst_sync_ff),
                    .hold(!run_sel[gi]),
                    .tick(IS_A ? tick_a_ff : tick_b_ff),
                    .frac_en(frac_ff[gi-4][FRAC_EN_LSB]),
                    .int_div(int_div_ff[gi]),
                    .pre_div(frac_ff[gi-4][FRAC_PRE_LSB +: PRE_W]),
                    .frac_word(frac_ff[gi-4][FRAC_W-1:0]),
                    .clk_out(div_out[gi])
                );
            end else begin : g_i
                odsc_divider u_div (
                    .clock(clock),
                    .rst_n(rst_sync_ff),
                    .hold(!run_sel[gi]),
                    .tick(IS_A ? tick_a_ff : tick_b_ff),
                    .frac_en(1'b0),
                    .int_div(int_div_ff[gi]),
                    .pre_div(MIN_FRAC_PRE),
                    .frac_word({FRAC_W{1'b0}}),
                    .clk_out(div_out[gi])
                );
            end
        end
    endgenerate

    // Output stage with bypass on 4 and 5, CMOS twin in phase
    always_ff @(posedge clock or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            out_ff <= '0;
            oe_b_ff <= '1;
            aux_ff <= '0;
            aux_oe_b_ff <= '1;
        end else begin
            for (int i = 0; i < NUM_OUT; i++) begin
                logic v;
                v = div_out[i];
                if (i == 4 || i == 5) begin
                    unique case (frac_ff[i-4][BYP_SEL_LSB +: 2])
                        ODSC_BYP_PRI: v = pri_ff;
                        ODSC_BYP_SEC: v = sec_ff;
                        default: v = div_out[i];
                    endcase
                end
                out_ff[i] <= v;
                aux_ff[i] <= v;
                // Request blocks main drive at once; aux drive waits on the run flags, which lag one cycle
                oe_b_ff[i] <= !(run_sel[i] && out_en_ff[i] && !sync_req);
                aux_oe_b_ff[i] <= !(run_sel[i] && out_en_ff[i] && i >= 4
                                    && fmt_ff[i*4 +: 2] == ODSC_FMT_MID
                                    && fmt_ff[i*4+3]);
            end
        end
    end

    // Format and slew per output
    always_ff @(posedge clock or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            drv_cfg <= '0;
            third_pole_resistor <= '0;
            third_pole_capacitor <= '0;
        end else begin
            for (int i = 0; i < NUM_OUT; i++) begin
                drv_cfg[i].fmt <= fmt_ff[i*4 +: 2];
                drv_cfg[i].slow_slew <= fmt_ff[i*4+2];
                drv_cfg[i].dual_cmos <= fmt_ff[i*4+3];
            end
            third_pole_resistor <= loop_ff[R3_LSB +: 4];
            third_pole_capacitor <= loop_ff[C3_LSB +: 4];
        end
    end

    // Read mux, data one cycle after strobe
    always_comb begin
        nxt_rdata = '0;
        if (reg_addr >= REG_INT_BASE && reg_addr < REG_INT_BASE + 5'h08) begin
            nxt_rdata = {22'h0, int_div_ff[reg_addr[2:0]]};
        end else if (reg_addr >= REG_FRAC_BASE && reg_addr < REG_FRAC_BASE + 5'h04) begin
            nxt_rdata = frac_ff[reg_addr[1:0]];
        end else begin
            unique case (reg_addr)
                REG_PRESCALE: nxt_rdata = prescale_ff;
                REG_LOOP: nxt_rdata = loop_ff;
                REG_OUT_EN: nxt_rdata = {24'h0, out_en_ff};
                REG_SYNC: nxt_rdata = sync_reg_ff;
                REG_STATUS: nxt_rdata = {28'h0, run_b_ff, run_a_ff, sync_req, sync_pin_ff};
                REG_FMT: nxt_rdata = fmt_ff;
                default: nxt_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            rdata_ff <= '0;
        end else if (reg_rd) begin
            rdata_ff <= nxt_rdata;
        end else begin
            rdata_ff <= '0;
        end
    end

    assign reg_rdata = rdata_ff;
    assign clk_out = out_ff;
    assign clk_out_oe_b = oe_b_ff;
    assign clk_out_aux = aux_ff;
    assign clk_out_aux_oe_b = aux_oe_b_ff;

    a_sync_tristate: assert property (@(posedge clock) disable iff (!rst_sync_ff)
        sync_req |=> &oe_b_ff) else $error("outputs driven during sync");
    a_sync_holds_run: assert property (@(posedge clock) disable iff (!rst_sync_ff)
        sync_req |=> !run_a_ff && !run_b_ff) else $error("run set during sync");
    a_disabled_stays_off: assert property (@(posedge clock) disable iff (!rst_sync_ff)
        !out_en_ff[0] |=> oe_b_ff[0]) else $error("disabled output on");
    a_run_needs_tick: assert property (@(posedge clock) disable iff (!rst_sync_ff)
        $rose(run_a_ff) |-> $past(rel_a_ff[1])) else $error("run without retime");
    a_soft_sync_req: assert property (@(posedge clock) disable iff (!rst_sync_ff)
        soft_sync |-> sync_req) else $error("soft sync ignored");
    a_release_bound: assert property (@(posedge clock) disable iff (!rst_sync_ff)
        $fell(sync_req) && ps_a_div <= 3'h4 ##1 !sync_req [*8] ##1 !sync_req [*2]
        |-> run_a_ff)
        else $error("release too slow");
    a_equal_prescale: assert property (@(posedge clock) disable iff (!rst_sync_ff)
        (ps_a_div == ps_b_div) && $stable(prescale_ff) && $past(ps_a_cnt_ff) == $past(ps_b_cnt_ff)
        |-> run_a_ff == run_b_ff) else $error("groups start apart");
    a_pole_follow: assert property (@(posedge clock) disable iff (!rst_sync_ff)
        $stable(loop_ff) |=> third_pole_resistor == $past(loop_ff[R3_LSB +: 4]))
        else $error("pole select stale");
endmodule

// *** test/odsc_rx_model.sv ***
// Downstream clock receiver model watching all eight output ports.
// Assumes it samples on the system clock; a released pin reads inverted.
`timescale 1ns/1ps
module odsc_rx_model
    import odsc_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Observed pins
    input wire logic [NUM_OUT-1:0] clk_out,
    input wire logic [NUM_OUT-1:0] clk_out_oe_b,
    input wire logic [NUM_OUT-1:0] clk_out_aux,
    input wire logic [NUM_OUT-1:0] clk_out_aux_oe_b,
    // Findings
    output logic [NUM_OUT-1:0] seen_edge,
    output int bad
);
    logic [NUM_OUT-1:0] last_ff;
    logic [NUM_OUT-1:0] line;

    // High impedance floats, so show the inverse rather than a stale level
    assign line = (clk_out & ~clk_out_oe_b) | (~last_ff & clk_out_oe_b);

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            last_ff <= '0;
            seen_edge <= '0;
            bad <= 0;
        end else begin
            last_ff <= line;
            seen_edge <= seen_edge | (line & ~last_ff & ~clk_out_oe_b);
            // Second CMOS signal must follow the first with no inversion
            if (((clk_out_aux ^ clk_out) & ~clk_out_aux_oe_b) != '0) begin
                bad <= bad + 1;
            end
        end
    end
endmodule

// *** test/odsc_top_bench.sv ***
// Self-checking bench for the output divider and sync control block.
// Assumes the receiver model above and the register port timing of the design.
`timescale 1ns/1ps
module odsc_top_bench;
    import odsc_pkg::*;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic sync_n = 1'b1;
    logic pri_clk = 1'b0;
    logic byp_on = 1'b0;
    logic [NUM_OUT-1:0] clk_out, oe_b, aux, aux_oe_b, seen;
    logic [3:0] res3, cap3;
    odsc_drv_t [NUM_OUT-1:0] drv;
    logic c4_q = 1'b0;
    int rise4 = 0;
    int bad, err_count = 0, n_checks = 0, cyc = 0, d1, d2;
    logic [31:0] q;

    odsc_top odsc_top_inst (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .output_sync_request_n(sync_n), .pri_clk_in(pri_clk), .sec_clk_in(1'b0),
        .clk_out(clk_out), .clk_out_oe_b(oe_b), .clk_out_aux(aux),
        .clk_out_aux_oe_b(aux_oe_b), .third_pole_resistor(res3),
        .third_pole_capacitor(cap3), .drv_cfg(drv));
    odsc_rx_model odsc_rx_model_inst (.clock(clock), .rst_b(rst_b), .clk_out(clk_out),
        .clk_out_oe_b(oe_b), .clk_out_aux(aux), .clk_out_aux_oe_b(aux_oe_b),
        .seen_edge(seen), .bad(bad));

    always #25 clock = ~clock;

    // Bypass source: a slow clock of eight system cycles per period
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (byp_on && (cyc % 4 == 0)) pri_clk <= ~pri_clk;
        c4_q <= clk_out[4];
        if (clk_out[4] && !c4_q) rise4 <= rise4 + 1;
        if (cyc == 20000) begin
            err_count = err_count + 1;
            results();
        end
    end

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("ERROR at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // Release the pin and count cycles until the outputs come on
    task automatic release_sync(output int d);
        d = 0;
        @(posedge clock);
        sync_n <= 1'b1;
        wt(1);
        while (oe_b === 8'hFF && d < 100) begin
            wt(1);
            d = d + 1;
        end
    endtask

    initial begin
        wt(12);
        rst_b <= 1'b1;
        wt(3);
        rd(REG_PRESCALE, q); chk(q, RST_PRESCALE);
        rd(REG_OUT_EN, q); chk(q, 32'h0000_0000);
        rd(REG_INT_BASE, q); chk(q, {22'h0, RST_INT_DIV});
        rd(REG_FRAC_BASE, q); chk(q, RST_FRAC);
        wr(5'h1F, 32'hFFFF_FFFF);
        rd(5'h1F, q); chk(q, 32'h0000_0000);
        wr(REG_INT_BASE, 32'hFFFF_FFFF);
        rd(REG_INT_BASE, q); chk(q, 32'h0000_03FF);
        for (int i = 0; i < NUM_OUT; i++) wr(REG_INT_BASE + 5'(i), 32'h0000_0002);
        wr(REG_LOOP, 32'h0000_00A5);
        wt(2);
        chk({24'h0, cap3, res3}, 32'h0000_00A5);
        // Output 4 CMOS dual slow, output 5 CMOS single, output 0 dual ignored
        wr(REG_FMT, 32'h002E_000E);
        wt(2);
        chk({20'h0, drv[5], drv[4], drv[0]}, 32'h0000_08BB);
        wr(REG_OUT_EN, 32'h0000_0001);
        wt(8);
        chk({24'h0, oe_b}, 32'h0000_00FE);
        wr(REG_OUT_EN, 32'h0000_00FF);
        wt(200);
        chk({24'h0, aux_oe_b}, 32'h0000_00EF);
        chk({24'h0, seen}, 32'h0000_00FF);
        chk(32'(bad), 32'h0);
        // Pin sync twice at different phases
        sync_n <= 1'b0;
        wt(4);
        chk({24'h0, oe_b}, 32'h0000_00FF);
        wt(20);
        chk({24'h0, clk_out}, 32'h0000_0000);
        release_sync(d1);
        chk({24'h0, oe_b}, 32'h0000_0000);
        wt(5);
        sync_n <= 1'b0;
        wt(9);
        release_sync(d2);
        chk({24'h0, oe_b}, 32'h0000_0000);
        chk(32'(d1 - d2 <= 4 && d2 - d1 <= 4 && d1 < 100), 32'h1);
        // Soft sync with one output left disabled
        wr(REG_OUT_EN, 32'h0000_00FD);
        wr(REG_SYNC, 32'h0000_0020);
        wt(4);
        chk({24'h0, oe_b}, 32'h0000_00FF);
        wr(REG_SYNC, 32'h0000_0000);
        wt(30);
        chk({24'h0, oe_b}, 32'h0000_0002);
        // Pre-divide below two is refused and held at the minimum
        wr(REG_FRAC_BASE + 5'h1, 32'h8010_0000);
        rd(REG_FRAC_BASE + 5'h1, q); chk(q, 32'h8020_0000);
        // Output 4 bypasses to the primary input
        wr(REG_FRAC_BASE, 32'h1000_0000);
        byp_on <= 1'b1;
        wt(40);
        d1 = rise4;
        wt(160);
        chk(32'(rise4 - d1 >= 19 && rise4 - d1 <= 21), 32'h1);
        results();
    end
endmodule
